/* File: hw/cbf_exec.sv */
// Execute stage for conditional flag branches and the three clear instructions.
//
// Contract
// - Branch-if-flag jumps to target when flag is one, else falls through.
// - Target is sign-extended 8-bit displacement times two plus pc plus four.
// - Reachable span is -256 to +254 bytes from the base address.
// - Plain flag branch takes three cycles taken, one cycle not taken.
// - Plain flag branch in a delay slot is an illegal slot instruction.
// - Delayed flag branch runs the slot first; two cycles taken, one not.
// - No interrupt accepted between a taken delayed branch and its slot.
// - Branch in the slot of a taken delayed branch is illegal.
// - Untaken delayed branch is a no-op; interrupts allowed, no slot check.
// - Branch updates commit before slot updates; flow changes after the slot.
// - Delayed target uses register values from before the slot instruction.
// - Accumulator-zero clears both halves in one cycle; condition flag unchanged.
// - Limit-flag zero clears the limit flag in one cycle, condition flag kept.
// - Condition-flag zero clears the flag in one cycle; pc advances.
`timescale 1ns/1ns
module cbf_exec
  import cbf_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Instruction issue from the fetch path.
  input wire logic insn_valid,
  input wire logic [15:0] insn,
  input wire logic [31:0] insn_pc,
  input wire logic insn_is_branch,
  // Flag set from other execute units.
  input wire logic cond_flag_set,
  input wire logic limit_flag_set,
  // Accumulator load from the multiply-accumulate unit.
  input wire logic acc_load,
  input wire logic [31:0] acc_high_in,
  input wire logic [31:0] acc_low_in,
  // Handshake and results.
  output logic insn_ready,
  output logic [31:0] pc_reg,
  output logic cond_flag_reg,
  output logic limit_flag_reg,
  output logic [31:0] acc_high_reg,
  output logic [31:0] acc_low_reg,
  output logic int_block,
  output logic illegal_slot_reg,
  output logic redirect_reg
);
  cbf_state_t state_reg;
  logic [1:0] wait_cnt_reg;
  logic [31:0] target_hold_reg;
  logic in_slot_reg;
  logic take;
  logic is_bt;
  logic is_bts;
  logic is_acc_zero;
  logic is_lim_zero;
  logic is_cond_zero;
  logic illegal;
  logic exec_ok;
  logic start_stall;
  logic start_slot;
  cbf_tgt_if tgt ();

  assign tgt.insn = insn;
  assign tgt.pc = insn_pc;
  cbf_target u_target (
    .t(tgt)
  );

  assign insn_ready = (state_reg != ST_WAIT);
  assign take = ce && insn_valid && insn_ready;
  assign is_bt = (insn[15:OPC_LSB] == OP_BRANCH_IF_FLAG);
  assign is_bts = (insn[15:OPC_LSB] == OP_BRANCH_IF_FLAG_DELAYED);
  assign is_acc_zero = (insn == OP_ACCUMULATOR_ZERO);
  assign is_lim_zero = (insn == OP_ZERO_LIMIT_FLAG);
  assign is_cond_zero = (insn == OP_ZERO_COND_FLAG);
  // A branch in the slot of a taken delayed branch is refused.
  assign illegal = in_slot_reg && (insn_is_branch || is_bt || is_bts);
  assign exec_ok = take && !illegal;
  // Only a take in the idle state can open a stall or a delay slot.
  assign start_stall = exec_ok && is_bt && cond_flag_reg && (state_reg == ST_IDLE);
  assign start_slot = exec_ok && is_bts && cond_flag_reg && (state_reg == ST_IDLE);
  // Interrupts are held off while the slot of a taken delayed branch is pending.
  assign int_block = in_slot_reg || (state_reg == ST_WAIT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_stall) begin
            state_reg <= ST_WAIT;
          end else if (start_slot) begin
            state_reg <= ST_SLOT;
          end
        end
        ST_WAIT: begin
          if (wait_cnt_reg == 2'h0) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SLOT: begin
          if (take) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Counts the extra stall cycles of a taken plain branch.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt_reg <= 2'h0;
    end else if (ce) begin
      if (start_stall) begin
        wait_cnt_reg <= CYC_TAKEN - CYC_NOT_TAKEN - 2'h1;
      end else if (state_reg == ST_WAIT && wait_cnt_reg != 2'h0) begin
        wait_cnt_reg <= wait_cnt_reg - 2'h1;
      end
    end
  end

  // Marks that the next accepted instruction is the slot of a taken delayed branch.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_slot_reg <= 1'b0;
    end else if (ce) begin
      if (start_slot) begin
        in_slot_reg <= 1'b1;
      end else if (take) begin
        in_slot_reg <= 1'b0;
      end
    end
  end

  // Delayed target is latched before the slot executes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      target_hold_reg <= RESET_PC;
    end else if (start_slot) begin
      target_hold_reg <= tgt.target;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_reg <= RESET_PC;
    end else if (ce) begin
      if (state_reg == ST_SLOT && exec_ok) begin
        pc_reg <= target_hold_reg;
      end else if (start_stall) begin
        pc_reg <= tgt.target;
      end else if (exec_ok) begin
        pc_reg <= insn_pc + INSN_BYTES;
      end
    end
  end

  // Pulses for one cycle when pc_reg was loaded with a branch target.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      redirect_reg <= 1'b0;
    end else if (ce) begin
      redirect_reg <= (state_reg == ST_SLOT && exec_ok) || start_stall;
    end
  end

  // Pulses for one cycle when a refused slot instruction is dropped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      illegal_slot_reg <= 1'b0;
    end else if (ce) begin
      illegal_slot_reg <= take && illegal;
    end
  end

  // An external set in the same cycle as a clear wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_flag_reg <= 1'b0;
    end else if (ce) begin
      if (cond_flag_set) begin
        cond_flag_reg <= 1'b1;
      end else if (exec_ok && is_cond_zero) begin
        cond_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      limit_flag_reg <= 1'b0;
    end else if (ce) begin
      if (limit_flag_set) begin
        limit_flag_reg <= 1'b1;
      end else if (exec_ok && is_lim_zero) begin
        limit_flag_reg <= 1'b0;
      end
    end
  end

  // A load from the multiply-accumulate unit in the same cycle as a clear wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_high_reg <= 32'h00000000;
      acc_low_reg <= 32'h00000000;
    end else if (ce) begin
      if (acc_load) begin
        acc_high_reg <= acc_high_in;
        acc_low_reg <= acc_low_in;
      end else if (exec_ok && is_acc_zero) begin
        acc_high_reg <= 32'h00000000;
        acc_low_reg <= 32'h00000000;
      end
    end
  end
endmodule

/* File: pkg/cbf_pkg.sv */
// Package with opcodes, fields and timing counts for the branch and flag-clear execute block.
package cbf_pkg;
  localparam logic [7:0] OP_BRANCH_IF_FLAG = 8'h89;
  localparam logic [7:0] OP_BRANCH_IF_FLAG_DELAYED = 8'h8d;
  localparam logic [15:0] OP_ACCUMULATOR_ZERO = 16'h0028;
  localparam logic [15:0] OP_ZERO_LIMIT_FLAG = 16'h0048;
  localparam logic [15:0] OP_ZERO_COND_FLAG = 16'h0008;
  localparam int DISP_MSB = 7;
  localparam int OPC_LSB = 8;
  localparam logic [31:0] INSN_BYTES = 32'h00000002;
  localparam logic [31:0] BASE_OFFSET = 32'h00000004;
  localparam logic [31:0] RESET_PC = 32'h00000000;
  localparam logic [1:0] CYC_TAKEN = 2'h3;
  localparam logic [1:0] CYC_TAKEN_DELAYED = 2'h2;
  localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SLOT = 3'b100
  } cbf_state_t;
endpackage

/* File: pkg/cbf_tgt_if.sv */
// Interface carrying instruction, instruction address and computed branch target.
`timescale 1ns/1ns
interface cbf_tgt_if;
  logic [15:0] insn;
  logic [31:0] pc;
  logic [31:0] target;
  modport calc (input insn, input pc, output target);
  modport user (output insn, output pc, input target);
endinterface

/* File: hw/cbf_target.sv */
// Branch target adder: sign-extended doubled displacement plus pc plus four.
`timescale 1ns/1ns
module cbf_target
  import cbf_pkg::*;
(
  cbf_tgt_if.calc t
);
  logic [31:0] disp_ext;
  // Span is -256..+254 bytes from the base address.
  assign disp_ext = {{23{t.insn[DISP_MSB]}}, t.insn[DISP_MSB:0], 1'b0};
  assign t.target = t.pc + BASE_OFFSET + disp_ext;
endmodule

/* File: verification/cbf_exec_checker.sv */
// Port-level assertions for the flag branch and clear execute block.
`timescale 1ns/1ns
module cbf_exec_checker
  import cbf_pkg::*;
(
  // Clock, reset and issue.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic insn_valid,
  input wire logic [15:0] insn,
  input wire logic [31:0] insn_pc,
  input wire logic insn_is_branch,
  input wire logic cond_flag_set,
  input wire logic limit_flag_set,
  input wire logic acc_load,
  // Results.
  input wire logic insn_ready,
  input wire logic [31:0] pc_reg,
  input wire logic cond_flag_reg,
  input wire logic limit_flag_reg,
  input wire logic [31:0] acc_high_reg,
  input wire logic [31:0] acc_low_reg,
  input wire logic int_block,
  input wire logic illegal_slot_reg,
  input wire logic redirect_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tk;
  logic sl;
  logic [31:0] tgt;
  // A take outside a slot, and a take of the slot itself.
  assign tk = ce && insn_valid && insn_ready && !int_block;
  assign sl = ce && insn_valid && insn_ready && int_block;
  assign tgt = insn_pc + 32'h4 + {{23{insn[7]}}, insn[7:0], 1'b0};
  sequence s_bt;
    tk && insn[15:8] == 8'h89 && cond_flag_reg;
  endsequence
  sequence s_stall;
    !insn_ready [*2] ##1 insn_ready;
  endsequence
  AST_BT_TARGET: assert property (s_bt |=> redirect_reg && pc_reg == $past(tgt))
    else $error("taken branch target wrong");
  AST_BT_STALL: assert property (s_bt |=> s_stall)
    else $error("taken branch cycle count wrong");
  AST_BT_FALL: assert property (tk && insn[15:8] == 8'h89 && !cond_flag_reg
    |=> insn_ready && pc_reg == $past(insn_pc) + 32'h2) else $error("fall through wrong");
  AST_BTS_SLOT: assert property (tk && insn[15:8] == 8'h8d && cond_flag_reg
    |=> int_block && pc_reg == $past(insn_pc) + 32'h2) else $error("delayed branch left early");
  AST_BTS_NOP: assert property (tk && insn[15:8] == 8'h8d && !cond_flag_reg
    |=> !int_block && pc_reg == $past(insn_pc) + 32'h2) else $error("untaken delayed wrong");
  AST_SLOT_JUMP: assert property (sl && !insn_is_branch |=> redirect_reg && !int_block)
    else $error("no jump after slot");
  AST_SLOT_ILL: assert property (sl && insn_is_branch |=> illegal_slot_reg)
    else $error("illegal slot missed");
  AST_ACC: assert property (tk && insn == 16'h0028 && !acc_load |=> acc_high_reg == 32'h0
    && acc_low_reg == 32'h0) else $error("accumulator not cleared");
  AST_LIM: assert property (tk && insn == 16'h0048 && !limit_flag_set && !cond_flag_set
    |=> !limit_flag_reg && $stable(cond_flag_reg)) else $error("limit flag clear wrong");
  AST_ZERO_COND_FLAG: assert property (tk && insn == 16'h0008 && !cond_flag_set
    |=> !cond_flag_reg && pc_reg == $past(insn_pc) + 32'h2) else $error("flag clear wrong");
endmodule
bind cbf_exec cbf_exec_checker chk_i (.*);

/* File: verification/cond_branch_and_flag_clear_tb.sv */
// Testbench for the flag branch and clear execute block.
`timescale 1ns/1ns
module cond_branch_and_flag_clear_tb;
  logic clk = 0, rst_n = 0, ce = 1, v = 0, br = 0, cs = 0, ls = 0, ld = 0;
  logic [31:0] ahi = 32'h0, ali = 32'h0;
  logic [15:0] insn = 16'h0009;
  logic [31:0] pc = 32'h0, pcr, ah, al;
  logic rdy, cf, lf, ib, il, rd;
  int fail_count = 0, n_tests = 0, k;
  always #4 clk = ~clk;
  cbf_exec DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .insn_valid(v), .insn(insn), .insn_pc(pc),
    .insn_is_branch(br), .cond_flag_set(cs), .limit_flag_set(ls), .insn_ready(rdy),
    .acc_load(ld), .acc_high_in(ahi), .acc_low_in(ali),
    .pc_reg(pcr), .cond_flag_reg(cf), .limit_flag_reg(lf), .acc_high_reg(ah),
    .acc_low_reg(al), .int_block(ib), .illegal_slot_reg(il), .redirect_reg(rd));
  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Offers one instruction, waits for it to be taken, returns mid-cycle after.
  task issue(input logic [15:0] w, input logic [31:0] a, input logic b);
    @(posedge clk);
    v <= 1;
    insn <= w;
    pc <= a;
    br <= b;
    @(negedge clk);
    for (k = 0; k < 8 && rdy !== 1'b1; k++) @(negedge clk);
    if (k == 8) begin
      fail_count++;
      report_and_stop;
    end
    @(posedge clk);
    v <= 0;
    @(negedge clk);
  endtask
  task setf(input logic c, input logic l);
    @(posedge clk);
    cs <= c;
    ls <= l;
    @(posedge clk);
    cs <= 0;
    ls <= 0;
    @(negedge clk);
  endtask
  task t_bt;
    setf(1, 0);
    issue(16'h8980, 32'h200, 1);
    chk(pcr, 32'h204 - 32'h100);
    chk({rd, rdy}, 2'b10);
    @(negedge clk);
    chk(rdy, 0);
    @(negedge clk);
    chk(rdy, 1);
    issue(16'h0008, 32'h300, 0);
    chk({cf, pcr[15:0]}, 17'h00302);
    issue(16'h897f, 32'h400, 1);
    chk({rd, rdy, pcr[15:0]}, 18'h10402);
  endtask
  task t_bts;
    setf(1, 1);
    issue(16'h8d7f, 32'h500, 1);
    chk({ib, pcr[15:0]}, 17'h10502);
    issue(16'h0028, 32'h502, 0);
    chk(pcr, 32'h504 + 32'h0fe);
    chk({rd, ib, cf}, 3'b101);
    chk(ah | al, 32'h0);
    issue(16'h8d00, 32'h800, 1);
    issue(16'h8902, 32'h802, 1);
    chk({il, rd, ib, pcr[15:0]}, 19'h40802);
  endtask
  task t_clr;
    issue(16'h0048, 32'h700, 0);
    chk({lf, cf, pcr[15:0]}, 18'h10702);
    issue(16'h0008, 32'h900, 0);
    issue(16'h8d10, 32'h902, 1);
    chk({ib, pcr[15:0]}, 17'h00904);
    issue(16'h8910, 32'h904, 1);
    chk({il, pcr[15:0]}, 17'h00906);
  endtask
  // Enable low freezes a clear, a set beats a clear, and a loaded accumulator is zeroed.
  task t_misc;
    setf(1, 0);
    @(posedge clk);
    ce <= 0;
    v <= 1;
    insn <= 16'h0008;
    repeat (2) @(posedge clk);
    v <= 0;
    ce <= 1;
    ld <= 1;
    ahi <= 32'h12345678;
    ali <= 32'h9abcdef0;
    @(posedge clk);
    ld <= 0;
    @(negedge clk);
    chk(cf, 1);
    chk(ah, 32'h12345678);
    @(posedge clk);
    v <= 1;
    cs <= 1;
    @(posedge clk);
    v <= 0;
    cs <= 0;
    @(negedge clk);
    chk(cf, 1);
    issue(16'h0028, 32'h910, 0);
    chk(ah | al, 32'h0);
    chk(cf, 1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    chk({rdy, ib, il, rd, cf, lf}, 6'h20);
    chk(pcr, 32'h0);
    t_bt;
    t_bts;
    t_clr;
    t_misc;
    report_and_stop;
  end
endmodule
